/* File: hw/usbfc_map.vh */
// register offsets, field positions, reset values and timing counts for the usb config bank
`ifndef USBFC_MAP_VH
`define USBFC_MAP_VH

`define ADDR_EXT_INDEX 16'h4038
`define ADDR_EXT_DATA 16'h403A
`define ADDR_INPUT_CTRL 16'h4040
`define ADDR_RSVD_4042 16'h4042
`define ADDR_PIN_STATUS 16'h4044
`define ADDR_IRQ_EN0 16'h4046

`define IDX_STRING_CTRL 8'h08
`define IDX_MAX_CURRENT 8'h09
`define IDX_TOGGLE_CTRL 8'h0A
`define IDX_RSVD_0B 8'h0B
`define IDX_FIFO_CTRL 8'h0C

`define RST_EXT_INDEX 8'h00
`define RST_STRING_CTRL 8'h01
`define RST_MAX_CURRENT 8'hFA
`define RST_TOGGLE_CTRL 8'h00
`define RST_RSVD_0B 8'h00
`define RST_FIFO_CTRL 8'h00
`define RST_INPUT_CTRL 7'h0D
`define RST_PULLUP 1'h0
`define RST_IRQ_EN0 8'h00

`define BIT_STRING_EN 0
`define BIT_EP4_TOGGLE 7
`define BIT_EP3_TOGGLE 6
`define BIT_EP2_TOGGLE 5
`define BIT_EP1_TOGGLE 4
`define BIT_FIFO_VALID_MODE 0
`define BIT_DIFF_RX_EN 6
`define BIT_BULK_MODE 3
`define BIT_WAKE_N 2
`define BIT_ATTACH_STATUS 1
`define BIT_PULLUP 0
`define BIT_IRQ_HOST_CONN 6
`define BIT_IRQ_BUS_RESET 1

// toggle write settles after this many usb function clocks
`define TOGGLE_SETTLE_CYCLES 4'd12
// attach sense must stay steady this long
`define ATTACH_STEADY_MS 500
`define CLK_HZ 40000000
`define ATTACH_STEADY_CYCLES ((`CLK_HZ / 1000) * `ATTACH_STEADY_MS)

`endif

/* File: hw/usb_function_config_regs.v */
// configuration and control register bank of the usb full-speed function
`timescale 1ns/100ps
`include "usbfc_map.vh"

module usb_function_config_regs #(
    parameter ATTACH_STEADY_CYCLES = `ATTACH_STEADY_CYCLES,
    parameter DEBOUNCE_WIDTH = 25
) (
    input wire CLK,
    input wire SRST,
    input wire [15:0] ADDR,
    input wire WR_EN,
    input wire RD_EN,
    input wire [15:0] WDATA,
    output reg [15:0] RDATA,
    output reg RDATA_VALID,
    input wire HOST_ATTACH_SENSE,
    input wire BUS_RESET_EVENT,
    input wire EP1_TOGGLE_FLIP,
    input wire EP2_TOGGLE_FLIP,
    input wire EP3_TOGGLE_FLIP,
    input wire EP4_TOGGLE_FLIP,
    input wire TX_FIFO_VALID,
    input wire TX_FIFO_HAS_DATA,
    output reg STRING_ENABLE,
    output reg [7:0] MAX_CURRENT,
    output reg [3:0] EP_DATA_TOGGLE,
    output reg TX_EP4_NAK,
    output reg DIFF_RECEIVER_ENABLE,
    output reg BULK_MODE,
    output reg REMOTE_WAKE_REQUEST_N,
    output reg PULLUP_CONTROL_OUTPUT,
    output reg HOST_CONNECTED_EVENT,
    output reg BUS_RESET_EVENT_OUT
);

    // ************************************************
    // register decode
    // ************************************************
    reg [7:0] ext_index_reg;
    reg [7:0] string_ctrl_reg;
    reg [7:0] max_current_reg;
    reg [7:0] toggle_reg;
    reg [7:0] rsvd_0b_reg;
    reg [7:0] fifo_ctrl_reg;
    reg [6:0] input_ctrl_reg;
    reg pullup_reg;
    reg [7:0] irq_en0_reg;

    wire wr_index = WR_EN && (ADDR == `ADDR_EXT_INDEX);
    wire wr_data = WR_EN && (ADDR == `ADDR_EXT_DATA);
    wire wr_str = wr_data && (ext_index_reg == `IDX_STRING_CTRL);
    wire wr_maxc = wr_data && (ext_index_reg == `IDX_MAX_CURRENT);
    wire wr_tog = wr_data && (ext_index_reg == `IDX_TOGGLE_CTRL);
    wire wr_r0b = wr_data && (ext_index_reg == `IDX_RSVD_0B);
    wire wr_fifo = wr_data && (ext_index_reg == `IDX_FIFO_CTRL);
    wire wr_inctl = WR_EN && (ADDR == `ADDR_INPUT_CTRL);
    wire wr_pin = WR_EN && (ADDR == `ADDR_PIN_STATUS);
    wire wr_irqen = WR_EN && (ADDR == `ADDR_IRQ_EN0);

    // ************************************************
    // plain control registers
    // ************************************************
    always @(posedge CLK) begin
        if (SRST) begin
            ext_index_reg <= `RST_EXT_INDEX;
            string_ctrl_reg <= `RST_STRING_CTRL;
            max_current_reg <= `RST_MAX_CURRENT;
            rsvd_0b_reg <= `RST_RSVD_0B;
            fifo_ctrl_reg <= `RST_FIFO_CTRL;
            input_ctrl_reg <= `RST_INPUT_CTRL;
            pullup_reg <= `RST_PULLUP;
            irq_en0_reg <= `RST_IRQ_EN0;
        end else begin
            if (wr_index) begin
                ext_index_reg <= WDATA[7:0];
            end
            if (wr_str) begin
                string_ctrl_reg <= WDATA[7:0];
            end
            // no clamp here: keeping the value at or below FAh is software's job
            if (wr_maxc) begin
                max_current_reg <= WDATA[7:0];
            end
            if (wr_r0b) begin
                rsvd_0b_reg <= WDATA[7:0];
            end
            if (wr_fifo) begin
                fifo_ctrl_reg <= WDATA[7:0];
            end
            if (wr_inctl) begin
                input_ctrl_reg <= WDATA[6:0];
            end
            if (wr_pin) begin
                pullup_reg <= WDATA[`BIT_PULLUP];
            end
            if (wr_irqen) begin
                irq_en0_reg <= WDATA[7:0];
            end
        end
    end

    // ************************************************
    // data toggles
    // ************************************************
    // a software write is parked and lands after the settle delay, so the
    // endpoint engine never sees a toggle change in the middle of a packet
    reg [7:0] toggle_pend_reg;
    reg [3:0] settle_reg;
    wire [3:0] flips = {EP4_TOGGLE_FLIP, EP3_TOGGLE_FLIP, EP2_TOGGLE_FLIP, EP1_TOGGLE_FLIP};
    wire commit = (settle_reg == 4'h1);

    always @(posedge CLK) begin
        if (SRST) begin
            toggle_pend_reg <= `RST_TOGGLE_CTRL;
            settle_reg <= 4'h0;
        end else if (wr_tog) begin
            toggle_pend_reg <= WDATA[7:0];
            // one settle cycle is spent in the read pipe, so a read issued on the
            // twelfth cycle after the write already sees the new value
            settle_reg <= `TOGGLE_SETTLE_CYCLES - 4'h1;
        end else if (settle_reg != 4'h0) begin
            settle_reg <= settle_reg - 4'h1;
        end
    end

    genvar g;
    wire [3:0] toggle_hi_next;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_toggle
            // a flip in the commit cycle is lost: the software value wins
            assign toggle_hi_next[g] = commit ? toggle_pend_reg[4 + g]
                : toggle_reg[4 + g] ^ flips[g];
        end
    endgenerate

    // reserved low bits simply hold what was written
    always @(posedge CLK) begin
        if (SRST) begin
            toggle_reg <= `RST_TOGGLE_CTRL;
        end else if (commit) begin
            toggle_reg <= {toggle_hi_next, toggle_pend_reg[3:0]};
        end else begin
            toggle_reg <= {toggle_hi_next, toggle_reg[3:0]};
        end
    end

    // ************************************************
    // attach sense synchroniser and debounce
    // ************************************************
    reg attach_meta_reg;
    reg attach_sync_reg;
    reg attach_prev_reg;
    reg attach_stable_reg;
    reg [DEBOUNCE_WIDTH-1:0] steady_cnt_reg;
    localparam [31:0] STEADY_LAST_FULL = ATTACH_STEADY_CYCLES - 1;
    wire [DEBOUNCE_WIDTH-1:0] steady_last = STEADY_LAST_FULL[DEBOUNCE_WIDTH-1:0];

    always @(posedge CLK) begin
        if (SRST) begin
            attach_meta_reg <= 1'h0;
            attach_sync_reg <= 1'h0;
        end else begin
            attach_meta_reg <= HOST_ATTACH_SENSE;
            attach_sync_reg <= attach_meta_reg;
        end
    end

    always @(posedge CLK) begin
        if (SRST) begin
            attach_prev_reg <= 1'h0;
            attach_stable_reg <= 1'h0;
            steady_cnt_reg <= {DEBOUNCE_WIDTH{1'b0}};
        end else begin
            attach_prev_reg <= attach_sync_reg;
            // status moves only after a full quiet interval, so bounce never reaches software
            if (attach_sync_reg != attach_prev_reg) begin
                steady_cnt_reg <= {DEBOUNCE_WIDTH{1'b0}};
            end else if (steady_cnt_reg != steady_last) begin
                steady_cnt_reg <= steady_cnt_reg + 1'b1;
            end else begin
                attach_stable_reg <= attach_prev_reg;
            end
        end
    end

    // ************************************************
    // connection events
    // ************************************************
    // events are edge pulses gated by the enable; the sticky status bits
    // live in the interrupt status block downstream
    reg stable_d_reg;
    reg bus_reset_d_reg;

    always @(posedge CLK) begin
        if (SRST) begin
            stable_d_reg <= 1'h0;
            bus_reset_d_reg <= 1'h0;
            HOST_CONNECTED_EVENT <= 1'h0;
            BUS_RESET_EVENT_OUT <= 1'h0;
        end else begin
            stable_d_reg <= attach_stable_reg;
            bus_reset_d_reg <= BUS_RESET_EVENT;
            HOST_CONNECTED_EVENT <= attach_stable_reg && !stable_d_reg
                && irq_en0_reg[`BIT_IRQ_HOST_CONN];
            BUS_RESET_EVENT_OUT <= BUS_RESET_EVENT && !bus_reset_d_reg
                && irq_en0_reg[`BIT_IRQ_BUS_RESET];
        end
    end

    // ************************************************
    // outputs to the usb core
    // ************************************************
    always @(posedge CLK) begin
        if (SRST) begin
            STRING_ENABLE <= 1'h0;
            MAX_CURRENT <= 8'h00;
            EP_DATA_TOGGLE <= 4'h0;
            TX_EP4_NAK <= 1'h1;
            DIFF_RECEIVER_ENABLE <= 1'h0;
            BULK_MODE <= 1'h0;
            REMOTE_WAKE_REQUEST_N <= 1'h1;
            PULLUP_CONTROL_OUTPUT <= 1'h0;
        end else begin
            STRING_ENABLE <= string_ctrl_reg[`BIT_STRING_EN];
            MAX_CURRENT <= max_current_reg;
            EP_DATA_TOGGLE <= toggle_reg[7:4];
            if (fifo_ctrl_reg[`BIT_FIFO_VALID_MODE]) begin
                TX_EP4_NAK <= !TX_FIFO_VALID;
            end else begin
                TX_EP4_NAK <= !TX_FIFO_HAS_DATA;
            end
            DIFF_RECEIVER_ENABLE <= input_ctrl_reg[`BIT_DIFF_RX_EN];
            BULK_MODE <= input_ctrl_reg[`BIT_BULK_MODE];
            REMOTE_WAKE_REQUEST_N <= input_ctrl_reg[`BIT_WAKE_N];
            PULLUP_CONTROL_OUTPUT <= pullup_reg;
        end
    end

    // ************************************************
    // read path
    // ************************************************
    reg [7:0] ext_rd;
    reg [15:0] rd_next;

    always @* begin
        case (ext_index_reg)
            `IDX_STRING_CTRL: ext_rd = string_ctrl_reg;
            `IDX_MAX_CURRENT: ext_rd = max_current_reg;
            `IDX_TOGGLE_CTRL: ext_rd = toggle_reg;
            `IDX_RSVD_0B: ext_rd = rsvd_0b_reg;
            `IDX_FIFO_CTRL: ext_rd = fifo_ctrl_reg;
            default: ext_rd = 8'h00;
        endcase
    end

    always @* begin
        case (ADDR)
            `ADDR_EXT_INDEX: rd_next = {8'h00, ext_index_reg};
            `ADDR_EXT_DATA: rd_next = {8'h00, ext_rd};
            `ADDR_INPUT_CTRL: rd_next = {9'h000, input_ctrl_reg};
            `ADDR_PIN_STATUS: rd_next = {14'h0000, attach_stable_reg, pullup_reg};
            `ADDR_IRQ_EN0: rd_next = {8'h00, irq_en0_reg};
            default: rd_next = 16'h0000;
        endcase
    end

    always @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 16'h0000;
            RDATA_VALID <= 1'h0;
        end else begin
            RDATA_VALID <= RD_EN;
            if (RD_EN) begin
                RDATA <= rd_next;
            end
        end
    end

endmodule // usb_function_config_regs

/* File: bench/usbfc_checker_properties.sv */
// concurrent checks on the ports of the usb config bank
`timescale 1ns/100ps
module usbfc_checker #(parameter ATTACH_STEADY_CYCLES = 16) (
    input wire CLK,
    input wire SRST,
    input wire [15:0] ADDR,
    input wire WR_EN,
    input wire RD_EN,
    input wire [15:0] WDATA,
    input wire RDATA_VALID,
    input wire HOST_ATTACH_SENSE,
    input wire BUS_RESET_EVENT,
    input wire TX_FIFO_VALID,
    input wire TX_FIFO_HAS_DATA,
    input wire STRING_ENABLE,
    input wire [7:0] MAX_CURRENT,
    input wire TX_EP4_NAK,
    input wire DIFF_RECEIVER_ENABLE,
    input wire BULK_MODE,
    input wire REMOTE_WAKE_REQUEST_N,
    input wire PULLUP_CONTROL_OUTPUT,
    input wire HOST_CONNECTED_EVENT,
    input wire BUS_RESET_EVENT_OUT
);
    // ********
    // helpers
    // ********
    reg [7:0] idx_reg;
    reg [31:0] high_reg;
    // raw pin count ignores the synchroniser, so it only bounds the event from below
    always @(posedge CLK) begin
        if (SRST)
            idx_reg <= 8'h00;
        else if (WR_EN && ADDR == 16'h4038)
            idx_reg <= WDATA[7:0];
        high_reg <= HOST_ATTACH_SENSE ? high_reg + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_ext_wr(i); WR_EN && ADDR == 16'h403A && idx_reg == i; endsequence
    sequence s_wr(a); WR_EN && ADDR == a; endsequence
    property p_rd_answer; RD_EN |=> RDATA_VALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_string; s_ext_wr(8'h08) |-> ##2 STRING_ENABLE == $past(WDATA[0], 2); endproperty
    a_string: assert property (p_string) else $error("string enable wrong");
    property p_current; s_ext_wr(8'h09) |-> ##2 MAX_CURRENT == $past(WDATA[7:0], 2); endproperty
    a_current: assert property (p_current) else $error("max current wrong");
    property p_input_ctrl;
        s_wr(16'h4040) |-> ##2 {DIFF_RECEIVER_ENABLE, BULK_MODE, REMOTE_WAKE_REQUEST_N}
            == {$past(WDATA[6], 2), $past(WDATA[3], 2), $past(WDATA[2], 2)};
    endproperty
    a_input_ctrl: assert property (p_input_ctrl) else $error("input ctrl wrong");
    property p_pullup;
        s_wr(16'h4044) |-> ##2 PULLUP_CONTROL_OUTPUT == $past(WDATA[0], 2);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up wrong");
    property p_nak;
        TX_FIFO_VALID == TX_FIFO_HAS_DATA |=> TX_EP4_NAK == !$past(TX_FIFO_VALID);
    endproperty
    a_nak: assert property (p_nak) else $error("nak wrong");
    property p_bus_reset;
        BUS_RESET_EVENT_OUT |-> $past(BUS_RESET_EVENT) && !$past(BUS_RESET_EVENT, 2);
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset event wrong");
    property p_host_event;
        HOST_CONNECTED_EVENT |-> high_reg >= ATTACH_STEADY_CYCLES ##1 !HOST_CONNECTED_EVENT;
    endproperty
    a_host_event: assert property (p_host_event) else $error("host event wrong");
endmodule // usbfc_checker
bind usb_function_config_regs usbfc_checker
    #(.ATTACH_STEADY_CYCLES(ATTACH_STEADY_CYCLES)) chk_inst (
    .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN), .WDATA(WDATA),
    .RDATA_VALID(RDATA_VALID), .HOST_ATTACH_SENSE(HOST_ATTACH_SENSE),
    .BUS_RESET_EVENT(BUS_RESET_EVENT), .TX_FIFO_VALID(TX_FIFO_VALID),
    .TX_FIFO_HAS_DATA(TX_FIFO_HAS_DATA), .STRING_ENABLE(STRING_ENABLE),
    .MAX_CURRENT(MAX_CURRENT), .TX_EP4_NAK(TX_EP4_NAK),
    .DIFF_RECEIVER_ENABLE(DIFF_RECEIVER_ENABLE), .BULK_MODE(BULK_MODE),
    .REMOTE_WAKE_REQUEST_N(REMOTE_WAKE_REQUEST_N),
    .PULLUP_CONTROL_OUTPUT(PULLUP_CONTROL_OUTPUT),
    .HOST_CONNECTED_EVENT(HOST_CONNECTED_EVENT), .BUS_RESET_EVENT_OUT(BUS_RESET_EVENT_OUT));

/* File: bench/usb_host_model.sv */
// behavioural usb host and core side feeding the bank's status inputs
`timescale 1ns/100ps
module usb_host_model (
    input wire clk,
    output reg sense,
    output reg bus_reset,
    output reg [3:0] flip,
    output reg fifo_valid,
    output reg fifo_has_data
);
    // ********
    // drivers
    // ********
    initial {sense, bus_reset, flip, fifo_valid, fifo_has_data} = 8'h00;
    // the attach pin is asynchronous to the bank; the synchroniser absorbs its phase
    task attach(input lvl, input integer n);
        begin
            @(posedge clk);
            #1 sense = lvl;
            repeat (n) @(posedge clk);
        end
    endtask
    task pulse(input [4:0] m);
        begin
            @(posedge clk);
            #1 {bus_reset, flip} = m;
            @(posedge clk);
            #1 {bus_reset, flip} = 5'h00;
        end
    endtask
    task fifo(input v, input d);
        begin
            @(posedge clk);
            #1 {fifo_valid, fifo_has_data} = {v, d};
        end
    endtask
endmodule // usb_host_model

/* File: bench/usb_function_config_regs_tb.sv */
// self-checking bench for the usb config bank
`timescale 1ns/100ps
module usb_function_config_regs_tb;
    localparam STEADY = 16;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg [15:0] addr = 16'h0000;
    reg [15:0] wdata = 16'h0000;
    reg [15:0] v, s;
    reg [15:0] exp_q[$];
    wire [15:0] rdata;
    wire [7:0] cur;
    wire [3:0] flip, tog;
    wire rvalid, sense, brst, fv, fd, str, nak, diff, bulk, wake_n, pup, hev, rev;
    integer n_mismatch = 0, checks_done = 0, cyc = 0, n_host = 0, n_rst = 0, i;
    always #12.5 clk = ~clk;
    usb_function_config_regs #(.ATTACH_STEADY_CYCLES(STEADY)) usb_function_config_regs_inst (
        .CLK(clk), .SRST(srst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata),
        .RDATA(rdata), .RDATA_VALID(rvalid), .HOST_ATTACH_SENSE(sense), .BUS_RESET_EVENT(brst),
        .EP1_TOGGLE_FLIP(flip[0]), .EP2_TOGGLE_FLIP(flip[1]), .EP3_TOGGLE_FLIP(flip[2]),
        .EP4_TOGGLE_FLIP(flip[3]), .TX_FIFO_VALID(fv), .TX_FIFO_HAS_DATA(fd),
        .STRING_ENABLE(str), .MAX_CURRENT(cur), .EP_DATA_TOGGLE(tog), .TX_EP4_NAK(nak),
        .DIFF_RECEIVER_ENABLE(diff), .BULK_MODE(bulk), .REMOTE_WAKE_REQUEST_N(wake_n),
        .PULLUP_CONTROL_OUTPUT(pup), .HOST_CONNECTED_EVENT(hev), .BUS_RESET_EVENT_OUT(rev));
    usb_host_model host_inst (.clk(clk), .sense(sense), .bus_reset(brst), .flip(flip),
        .fifo_valid(fv), .fifo_has_data(fd));
    // ********
    // tasks
    // ********
    task chk(input [15:0] got, input [15:0] want);
        begin
            checks_done = checks_done + 1;
            if (got !== want) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
            end
        end
    endtask
    // one access: w=1 writes d, w=0 reads and notes d as the expected answer
    task acc(input w, input [15:0] a, input [15:0] d);
        begin
            @(posedge clk);
            #1 {wr_en, rd_en, addr, wdata} = {w, !w, a, w ? d : 16'h0000};
            if (!w)
                exp_q.push_back(d);
            @(posedge clk);
            #1 {wr_en, rd_en} = 2'b00;
        end
    endtask
    task ext(input w, input [7:0] idx, input [15:0] d);
        begin
            acc(1'b1, 16'h4038, {8'h00, idx});
            acc(w, 16'h403A, d);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // answers and event pulses are sampled mid-cycle, clear of the edge
    always @(negedge clk) begin
        cyc = cyc + 1;
        n_host = n_host + (hev === 1'b1);
        n_rst = n_rst + (rev === 1'b1);
        if (rvalid === 1'b1)
            chk(rdata, exp_q.pop_front());
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    // ********
    // tests
    // ********
    initial begin
        v = $urandom(32'h5AAA98EE);
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        acc(0, 16'h4040, 16'h000D);
        acc(0, 16'h4046, 16'h0000);
        acc(0, 16'h4044, 16'h0000);
        for (i = 8; i < 13; i = i + 1)
            ext(0, i[7:0], i == 8 ? 16'h0001 : i == 9 ? 16'h00FA : 16'h0000);
        chk({str, bulk, wake_n, diff, cur}, 16'h0EFA);
        $display("reset test done");
        for (i = 0; i < 4; i = i + 1) begin
            v = $urandom & 16'h004C;
            acc(1, 16'h4040, v);
            acc(0, 16'h4040, v);
            chk({diff, bulk, wake_n}, {v[6], v[3], v[2]});
            s = $urandom & 16'h0001;
            ext(1, 8'h08, s);
            v = $urandom % 251;
            ext(1, 8'h09, v);
            ext(0, 8'h09, v);
            chk({str, cur}, {s[0], v[7:0]});
        end
        acc(1, 16'h4042, 16'hFFFF);
        acc(0, 16'h4042, 16'h0000);
        ext(1, 8'h20, 16'h00FF);
        ext(0, 8'h20, 16'h0000);
        ext(1, 8'h07, 16'h0004);
        ext(0, 8'h07, 16'h0000);
        $display("control test done");
        s = $urandom & 16'h00F0;
        ext(1, 8'h0A, s);
        acc(0, 16'h403A, 16'h0000);
        repeat (8) @(posedge clk);
        acc(0, 16'h403A, s);
        chk(tog, s[7:4]);
        host_inst.pulse(5'h0F);
        acc(0, 16'h403A, s ^ 16'h00F0);
        chk(tog, s[7:4] ^ 4'hF);
        $display("toggle test done");
        for (i = 0; i < 8; i = i + 1) begin
            ext(1, 8'h0C, i >> 2);
            host_inst.fifo(i[1], i[0]);
            repeat (2) @(posedge clk);
            #1 chk(nak, i[2] ? !i[1] : !i[0]);
        end
        $display("nak test done");
        acc(1, 16'h4046, 16'h0042);
        host_inst.pulse(5'h10);
        // interrupted high periods longer in sum than the steady time
        host_inst.attach(1'b1, 8);
        host_inst.attach(1'b0, 2);
        host_inst.attach(1'b1, 8);
        host_inst.attach(1'b0, 4);
        acc(0, 16'h4044, 16'h0000);
        host_inst.attach(1'b1, STEADY + 8);
        acc(0, 16'h4044, 16'h0002);
        acc(1, 16'h4044, 16'h0001);
        acc(1, 16'h4046, 16'h0000);
        host_inst.pulse(5'h10);
        host_inst.attach(1'b0, STEADY + 8);
        host_inst.attach(1'b1, STEADY + 8);
        acc(0, 16'h4044, 16'h0003);
        chk({pup, n_host[3:0], n_rst[3:0]}, 16'h0111);
        $display("event test done");
        test_done;
    end
endmodule // usb_function_config_regs_tb
